// ==== core/tldf_cfg.svh ====
// Bit positions, reset values and sizes for the talker/listener data flags
`ifndef TLDF_CFG_SVH
`define TLDF_CFG_SVH

// Status and mask bit positions (interrupt_status_one / interrupt_mask_one)
`define TLDF_BIT_DATA_IN   0
`define TLDF_BIT_DATA_OUT  1
`define TLDF_BIT_LOST_BYTE 2

// Outgoing DMA enable position in interrupt_mask_two
`define TLDF_BIT_DMA_OUT   5

// Reset values
`define TLDF_RST_BYTE      8'h00
`define TLDF_RST_FLAG      1'b0

// Outgoing byte buffer shape
`define TLDF_FIFO_WIDTH    8
`define TLDF_FIFO_DEPTH    16

`endif

// ==== core/tldf_pkg.sv ====
// Types shared by the talker/listener data flag block
package tldf_pkg;

  // One register or data byte
  typedef logic [7:0] tldf_byte_t;

  // Listener handshake mode set by auxiliary commands
  typedef enum logic [0:0] {
    TLDF_LM_NORMAL,
    TLDF_LM_CONTINUOUS
  } tldf_lmode_t;

endpackage : tldf_pkg

// ==== core/tldf_fifo_if.sv ====
// Valid/ready carrier between the flag block and its outgoing byte buffer
`timescale 1ns/1ps
interface tldf_fifo_if #(
  parameter int WIDTH = 8
);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;

  // Buffer side
  modport fifo (
    input  wr_valid,
    input  wr_data,
    output wr_ready,
    output rd_valid,
    output rd_data,
    input  rd_ready
  );

  // User side
  modport user (
    output wr_valid,
    output wr_data,
    input  wr_ready,
    input  rd_valid,
    input  rd_data,
    output rd_ready
  );
endinterface : tldf_fifo_if

// ==== core/tldf_fifo.sv ====
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`include "tldf_cfg.svh"
module tldf_fifo
  import tldf_pkg::*;
#(
  parameter int WIDTH = `TLDF_FIFO_WIDTH,
  parameter int DEPTH = `TLDF_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  // Carrier
  tldf_fifo_if.fifo bus
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic [AW:0]      nxt_count;
  logic             full_ff;
  logic             push;
  logic             pop;

  // Handshakes on both sides
  assign push         = bus.wr_valid & ~full_ff;
  assign pop          = bus.rd_ready & (count_ff != '0);
  assign bus.wr_ready = ~full_ff;
  assign bus.rd_valid = (count_ff != '0);
  assign bus.rd_data  = mem_ff[rd_ptr_ff];

  // Occupancy after this cycle
  always_comb
  begin
    nxt_count = count_ff;
    if (push && !pop)
      nxt_count = count_ff + 1'b1;
    else if (pop && !push)
      nxt_count = count_ff - 1'b1;
  end

  // Pointers, count and full flag
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
      full_ff   <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      count_ff <= nxt_count;
      full_ff  <= (nxt_count == (AW+1)'(DEPTH));
    end
  end

  // Storage, no reset needed
  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= bus.wr_data;
  end
endmodule : tldf_fifo

// ==== core/tldf_flags.sv ====
// Data-transfer status flags, masks and outgoing byte path of the talker/listener
`timescale 1ns/1ps
`include "tldf_cfg.svh"
// Operation
// - Host byte write while source idle or entering idle sets lost-byte flag.
// - Byte sent on the bus with no listener present sets lost-byte flag.
// - Reset and status read clear lost-byte and data-in flags.
// - Data-out flag, bit 1, sets on rising talker-active and source-generate; enable bit 1.
// - Data-out flag clears on status read, talker inactive or source-generate false.
// - Host write of the command/data out register clears data-out flag.
// - Interrupt request while data-out flag and its enable are both set.
// - Outgoing DMA enable turns data-out flag into a DMA cycle request.
// - Data-in flag, bit 0, sets in listener-active, accept-data, continuous mode; enable bit 0.
// - Data-in flag clears on finish-handshake in holdoff, or data-in register read.
// - Continuous mode follows its auxiliary command; holdoff is ready-for-data holdoff.
module tldf_flags
  import tldf_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  // Host register strobes
  input  wire logic       status_rd_i,
  input  wire logic       mask_one_wr_i,
  input  wire tldf_byte_t mask_one_data_i,
  input  wire logic       mask_two_wr_i,
  input  wire tldf_byte_t mask_two_data_i,
  input  wire logic       out_byte_wr_i,
  input  wire tldf_byte_t out_byte_data_i,
  input  wire logic       dir_rd_i,
  // Auxiliary commands
  input  wire logic       aux_cont_on_i,
  input  wire logic       aux_cont_off_i,
  input  wire logic       aux_finish_hs_i,
  // Bus function states
  input  wire logic       tacs_i,
  input  wire logic       sgns_i,
  input  wire logic       sids_i,
  input  wire logic       sdys_to_sids_i,
  input  wire logic       lacs_i,
  input  wire logic       acds_i,
  input  wire logic       rfd_holdoff_i,
  input  wire logic       byte_sent_i,
  input  wire logic       no_listener_i,
  // Outgoing byte stream toward the source handshake
  output tldf_byte_t      tx_data_o,
  output logic            tx_valid_o,
  input  wire logic       tx_ready_i,
  output logic            out_byte_ready_o,
  // Host answers
  output tldf_byte_t      status_data_o,
  output logic            irq_o,
  output logic            dma_req_o,
  output logic            cont_mode_o
);

  tldf_fifo_if #(.WIDTH(`TLDF_FIFO_WIDTH)) fifo_bus ();

  tldf_lmode_t lmode_ff;
  logic        data_in_flag_ff;
  logic        data_out_flag_ff;
  logic        lost_byte_flag_ff;
  logic        nxt_data_in_flag;
  logic        nxt_data_out_flag;
  logic        nxt_lost_byte_flag;
  logic        data_in_irq_enable_ff;
  logic        data_out_irq_enable_ff;
  logic        lost_byte_irq_enable_ff;
  logic        outgoing_dma_enable_ff;
  logic        talk_ready_prev_ff;
  logic        talk_ready;
  logic        do_set;
  logic        do_clr;
  logic        din_set;
  logic        din_clr;
  logic        err_set;
  tldf_byte_t  tx_data_ff;
  logic        tx_valid_ff;
  logic        tx_load;
  logic        out_byte_ready_ff;
  tldf_byte_t  status_data_ff;
  logic        irq_ff;
  logic        dma_req_ff;

  // Outgoing byte buffer between the host and the source handshake
  tldf_fifo #(
    .WIDTH (`TLDF_FIFO_WIDTH),
    .DEPTH (`TLDF_FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .bus    (fifo_bus)
  );

  // Host writes fill the buffer; output stage drains it
  assign fifo_bus.wr_valid = out_byte_wr_i;
  assign fifo_bus.wr_data  = out_byte_data_i;
  assign tx_load           = fifo_bus.rd_valid & (~tx_valid_ff | tx_ready_i);
  assign fifo_bus.rd_ready = tx_load;

  // Registered output stage of the byte stream
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      tx_valid_ff <= 1'b0;
      tx_data_ff  <= `TLDF_RST_BYTE;
    end
    else if (tx_load)
    begin
      tx_valid_ff <= 1'b1;
      tx_data_ff  <= fifo_bus.rd_data;
    end
    else if (tx_ready_i)
    begin
      tx_valid_ff <= 1'b0;
    end
  end

  // Buffer space as seen by the host, registered
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      out_byte_ready_ff <= 1'b0;
    else
      out_byte_ready_ff <= fifo_bus.wr_ready;
  end

  // Listener mode from auxiliary commands, turn-on wins
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      lmode_ff <= TLDF_LM_NORMAL;
    else
    begin
      case (lmode_ff)
        TLDF_LM_NORMAL:
          if (aux_cont_on_i)
            lmode_ff <= TLDF_LM_CONTINUOUS;
        TLDF_LM_CONTINUOUS:
          if (aux_cont_off_i && !aux_cont_on_i)
            lmode_ff <= TLDF_LM_NORMAL;
        default:
          lmode_ff <= TLDF_LM_NORMAL;
      endcase
    end
  end

  // Mask registers, write only
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      data_in_irq_enable_ff   <= `TLDF_RST_FLAG;
      data_out_irq_enable_ff  <= `TLDF_RST_FLAG;
      lost_byte_irq_enable_ff <= `TLDF_RST_FLAG;
      outgoing_dma_enable_ff  <= `TLDF_RST_FLAG;
    end
    else
    begin
      if (mask_one_wr_i)
      begin
        data_in_irq_enable_ff   <= mask_one_data_i[`TLDF_BIT_DATA_IN];
        data_out_irq_enable_ff  <= mask_one_data_i[`TLDF_BIT_DATA_OUT];
        lost_byte_irq_enable_ff <= mask_one_data_i[`TLDF_BIT_LOST_BYTE];
      end
      if (mask_two_wr_i)
        outgoing_dma_enable_ff <= mask_two_data_i[`TLDF_BIT_DMA_OUT];
    end
  end

  // Set and clear terms of each flag
  assign talk_ready = tacs_i & sgns_i;
  assign do_set     = talk_ready & ~talk_ready_prev_ff;
  assign do_clr     = status_rd_i | ~tacs_i | ~sgns_i | out_byte_wr_i;
  assign err_set    = (out_byte_wr_i & (sids_i | sdys_to_sids_i))
                    | (byte_sent_i & no_listener_i);
  assign din_set    = lacs_i & acds_i & (lmode_ff == TLDF_LM_CONTINUOUS);
  assign din_clr    = status_rd_i
                    | (aux_finish_hs_i & rfd_holdoff_i)
                    | dir_rd_i;

  // Next flag values, a set beats a clear in the same cycle
  assign nxt_data_out_flag  = do_set | (data_out_flag_ff & ~do_clr);
  assign nxt_lost_byte_flag = err_set | (lost_byte_flag_ff & ~status_rd_i);
  assign nxt_data_in_flag   = din_set | (data_in_flag_ff & ~din_clr);

  // Status flags and the edge detector of the talker condition
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      data_out_flag_ff   <= `TLDF_RST_FLAG;
      lost_byte_flag_ff  <= `TLDF_RST_FLAG;
      data_in_flag_ff    <= `TLDF_RST_FLAG;
      talk_ready_prev_ff <= 1'b0;
    end
    else
    begin
      data_out_flag_ff   <= nxt_data_out_flag;
      lost_byte_flag_ff  <= nxt_lost_byte_flag;
      data_in_flag_ff    <= nxt_data_in_flag;
      talk_ready_prev_ff <= talk_ready;
    end
  end

  // Status read captures the flags as they stood before the clear
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      status_data_ff <= `TLDF_RST_BYTE;
    else if (status_rd_i)
    begin
      status_data_ff                      <= `TLDF_RST_BYTE;
      status_data_ff[`TLDF_BIT_DATA_IN]   <= data_in_flag_ff;
      status_data_ff[`TLDF_BIT_DATA_OUT]  <= data_out_flag_ff;
      status_data_ff[`TLDF_BIT_LOST_BYTE] <= lost_byte_flag_ff;
    end
  end

  // Interrupt and DMA requests follow the flags with no extra delay
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      irq_ff     <= 1'b0;
      dma_req_ff <= 1'b0;
    end
    else
    begin
      irq_ff     <= (nxt_data_out_flag & data_out_irq_enable_ff)
                  | (nxt_data_in_flag & data_in_irq_enable_ff)
                  | (nxt_lost_byte_flag & lost_byte_irq_enable_ff);
      dma_req_ff <= nxt_data_out_flag & outgoing_dma_enable_ff;
    end
  end

  // Outputs straight from flip-flops
  assign tx_data_o    = tx_data_ff;
  assign tx_valid_o   = tx_valid_ff;
  assign out_byte_ready_o = out_byte_ready_ff;
  assign status_data_o    = status_data_ff;
  assign irq_o        = irq_ff;
  assign dma_req_o    = dma_req_ff;
  assign cont_mode_o  = (lmode_ff == TLDF_LM_CONTINUOUS);

endmodule : tldf_flags

// ==== dv/tldf_flags_properties.sv ====
// Port checker for the talker/listener data flag block
`timescale 1ns/1ps
module tldf_flags_chk
  import tldf_pkg::*;
(
  // Clock, reset and host strobes
  input wire logic       mclk_i, rstn_i, status_rd_i, out_byte_wr_i, dir_rd_i,
  // Auxiliary commands and bus states
  input wire logic       aux_cont_on_i, aux_cont_off_i, tacs_i, sgns_i, sids_i,
  input wire logic       sdys_to_sids_i, lacs_i, acds_i, byte_sent_i, no_listener_i,
  // Outputs watched, with the stream ready input
  input wire logic       tx_valid_o, tx_ready_i, dma_req_o, cont_mode_o,
  input wire tldf_byte_t tx_data_o, status_data_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // Talker ready, quiet cycle and data-in set terms
  wire tk  = tacs_i && sgns_i;
  wire qt  = !lacs_i && !out_byte_wr_i && !byte_sent_i && !tacs_i;
  wire din = lacs_i && acds_i && cont_mode_o;
  a_lost_write: assert property (out_byte_wr_i && (sids_i || sdys_to_sids_i)
    ##1 !status_rd_i ##1 status_rd_i |=> status_data_o[2]) else $error("lost write missed");
  a_lost_send: assert property (byte_sent_i && no_listener_i
    ##1 !status_rd_i ##1 status_rd_i |=> status_data_o[2]) else $error("lost send missed");
  a_read_clears: assert property (status_rd_i && qt ##1 qt ##1 status_rd_i
    |=> status_data_o[2:0] == 3'h0) else $error("flags kept after read");
  a_dout_set: assert property ($rose(tk) ##1 tk && !out_byte_wr_i && !status_rd_i
    ##1 status_rd_i |=> status_data_o[1]) else $error("data out not set");
  a_dout_drop: assert property (!tk |=> !dma_req_o) else $error("dma kept");
  a_dout_write: assert property (out_byte_wr_i && !$rose(tk) |=> !dma_req_o)
    else $error("dma kept after write");
  a_din_set: assert property (din [*2] ##1 status_rd_i |=> status_data_o[0])
    else $error("data in not set");
  a_din_read: assert property (dir_rd_i && !lacs_i ##1 !lacs_i ##1 status_rd_i
    |=> !status_data_o[0]) else $error("data in kept");
  a_mode_on: assert property (aux_cont_on_i |=> cont_mode_o) else $error("mode on");
  a_mode_off: assert property (aux_cont_off_i && !aux_cont_on_i |=> !cont_mode_o)
    else $error("mode off");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i
    |=> tx_valid_o && $stable(tx_data_o)) else $error("stream byte dropped");
  // Main scenarios reached
  c_dma: cover property ($rose(dma_req_o));
  c_coincide: cover property (status_rd_i && out_byte_wr_i && sids_i);
  c_stall: cover property (tx_valid_o && !tx_ready_i);
endmodule : tldf_flags_chk
bind tldf_flags tldf_flags_chk u_chk (.mclk_i, .rstn_i, .status_rd_i, .out_byte_wr_i,
  .dir_rd_i, .aux_cont_on_i, .aux_cont_off_i, .tacs_i, .sgns_i, .sids_i, .sdys_to_sids_i,
  .lacs_i, .acds_i, .byte_sent_i, .no_listener_i, .tx_valid_o, .tx_ready_i, .dma_req_o,
  .cont_mode_o, .tx_data_o, .status_data_o);

// ==== dv/tldf_bus_model.sv ====
// Source handshake model that takes outgoing bytes onto the bus
`timescale 1ns/1ps
module tldf_bus_model
  import tldf_pkg::*;
(
  // Clock, reset and stall control
  input  wire logic       mclk_i, rstn_i, stall_i,
  // Outgoing stream
  input  wire logic       tx_valid_i,
  input  wire tldf_byte_t tx_data_i,
  output logic            tx_ready_o,
  output logic            byte_sent_o
);
  tldf_byte_t got_q[$];
  // Ready unless held off by the bench
  assign tx_ready_o = !stall_i;
  // Take a byte at each handshake and report it sent a cycle later
  always_ff @(posedge mclk_i)
  begin
    byte_sent_o <= rstn_i && tx_valid_i && tx_ready_o;
    if (rstn_i && tx_valid_i && tx_ready_o)
      got_q.push_back(tx_data_i);
  end
endmodule : tldf_bus_model

// ==== dv/tb_tldf_flags.sv ====
// Self-checking bench for the talker/listener data flags
`timescale 1ns/1ps
module tb_tldf_flags;
  import tldf_pkg::*;
  logic       mclk_i, rstn_i, stall, sent, tx_valid_o, tx_ready_i;
  logic       out_byte_ready_o, irq_o, dma_req_o, cont_mode_o;
  logic [7:0] st, lv;
  tldf_byte_t dat, tx_data_o, status_data_o;
  int         err_total, num_checks, k;
  tldf_flags i_dut (.mclk_i, .rstn_i, .status_rd_i(st[0]), .mask_one_wr_i(st[1]),
    .mask_one_data_i(dat), .mask_two_wr_i(st[2]), .mask_two_data_i(dat),
    .out_byte_wr_i(st[3]), .out_byte_data_i(dat), .dir_rd_i(st[4]), .aux_cont_on_i(st[5]),
    .aux_cont_off_i(st[6]), .aux_finish_hs_i(st[7]), .tacs_i(lv[0]), .sgns_i(lv[1]),
    .sids_i(lv[2]), .sdys_to_sids_i(lv[3]), .lacs_i(lv[4]), .acds_i(lv[5]),
    .rfd_holdoff_i(lv[6]), .byte_sent_i(sent), .no_listener_i(lv[7]), .tx_data_o,
    .tx_valid_o, .tx_ready_i, .out_byte_ready_o, .status_data_o, .irq_o, .dma_req_o,
    .cont_mode_o);
  tldf_bus_model i_bus (.mclk_i, .rstn_i, .stall_i(stall), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i), .byte_sent_o(sent));
  // Compare one value
  task chk(string nm, logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One-cycle host strobes with data
  task pls(logic [7:0] m, tldf_byte_t d);
    @(posedge mclk_i);
    st <= m;
    dat <= d;
    @(posedge mclk_i);
    st <= 8'h00;
  endtask : pls
  // Bus state levels, sampled at the second edge
  task lvl(logic [7:0] v);
    @(posedge mclk_i);
    lv <= v;
    @(posedge mclk_i);
  endtask : lvl
  task wt;
    @(posedge mclk_i);
    #1;
  endtask : wt
  // Status read and compare
  task rd(logic [7:0] exp);
    pls(8'h01, 8'h00);
    #1;
    chk("status", status_data_o, exp);
  endtask : rd
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // Clock
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // Watchdog
  initial
  begin
    #100000;
    err_total++;
    report_and_stop;
  end
  // Test sequence
  initial
  begin
    {rstn_i, st, lv, dat, stall, err_total, num_checks} = '0;
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1'b1;
    wt;
    chk("irq", irq_o, 8'h00);
    chk("dma", dma_req_o, 8'h00);
    chk("cont", cont_mode_o, 8'h00);
    rd(8'h00);
    rd(8'h00);
    $display("test reset done");
    pls(8'h02, 8'h02);
    lvl(8'h03);
    #1;
    chk("irq", irq_o, 8'h01);
    pls(8'h02, 8'h00);
    wt;
    chk("irq", irq_o, 8'h00);
    pls(8'h04, 8'h20);
    wt;
    chk("dma", dma_req_o, 8'h01);
    pls(8'h08, 8'h11);
    #1;
    chk("dma", dma_req_o, 8'h00);
    lvl(8'h00);
    lvl(8'h03);
    #1;
    chk("dma", dma_req_o, 8'h01);
    lvl(8'h01);
    #1;
    chk("dma", dma_req_o, 8'h00);
    lvl(8'h03);
    rd(8'h02);
    chk("dma", dma_req_o, 8'h00);
    rd(8'h00);
    pls(8'h04, 8'h00);
    $display("test data out done");
    lvl(8'h04);
    pls(8'h08, 8'h22);
    rd(8'h04);
    lvl(8'h08);
    pls(8'h08, 8'h33);
    rd(8'h04);
    lvl(8'h04);
    pls(8'h09, 8'h44);
    #1;
    chk("status", status_data_o, 8'h00);
    rd(8'h04);
    lvl(8'h80);
    pls(8'h08, 8'h55);
    repeat (3) wt;
    rd(8'h04);
    rd(8'h00);
    $display("test lost byte done");
    pls(8'h20, 8'h00);
    #1;
    chk("cont", cont_mode_o, 8'h01);
    lvl(8'h30);
    rd(8'h01);
    lvl(8'h00);
    pls(8'h10, 8'h00);
    rd(8'h00);
    lvl(8'h30);
    lvl(8'h00);
    pls(8'h80, 8'h00);
    rd(8'h01);
    lvl(8'h30);
    lvl(8'h40);
    pls(8'h80, 8'h00);
    rd(8'h00);
    pls(8'h40, 8'h00);
    #1;
    chk("cont", cont_mode_o, 8'h00);
    lvl(8'h30);
    rd(8'h00);
    lvl(8'h00);
    $display("test data in done");
    @(posedge mclk_i);
    stall <= 1'b1;
    k = 0;
    while (out_byte_ready_o === 1'b1 && k < 40)
    begin
      pls(8'h08, 8'h60 + 8'(k));
      // Ready lags the buffer by a cycle, so look one edge after the write
      wt;
      k++;
    end
    chk("fill", 8'(k), 8'h11);
    @(posedge mclk_i);
    stall <= 1'b0;
    repeat (40) wt;
    chk("valid", tx_valid_o, 8'h00);
    chk("count", 8'(i_bus.got_q.size()), 8'h16);
    for (int i = 0; i < 22; i++)
      chk("byte", i_bus.got_q[i], i < 5 ? 8'h11 * 8'(i + 1) : 8'h60 + 8'(i - 5));
    $display("test stream done");
    report_and_stop;
  end
endmodule : tb_tldf_flags
